// file: inc/fbst_pkg.sv
// constants and types shared by the boundary-scan test port
package fbst_pkg;

   // =========================================================
   // register widths and capture values
   localparam int          IR_W       = 4;
   localparam int          ID_W       = 32;
   localparam logic [3:0]  IR_CAPTURE = 4'h1;        // low bits 01 on capture
   localparam logic [3:0]  OP_IDCODE  = 4'h2;
   localparam logic [3:0]  OP_BYPASS  = 4'hf;
   localparam logic [31:0] ID_DEFAULT = 32'h0000_0001; // arbitrary value, lsb must be 1

   // =========================================================
   // tap reset by mode select
   localparam int          RESET_ONES = 5;           // consecutive high samples
   localparam logic [2:0]  ONES_LAST  = 3'h4;        // count before the fifth sample
   localparam logic [2:0]  ONES_MAX   = 3'h5;

   // =========================================================
   // controller states
   typedef enum logic [3:0] {
      S_TLR, S_RTI,
      S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
      S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
   } fbst_state_t;

endpackage

// file: rtl/fbst_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module fbst_pin_sync #(
   parameter logic INIT = 1'b0                     // idle level of the pin
) (
   input  wire logic CLK,                          // system clock
   input  wire logic RST,                          // async reset, active high
   input  wire logic PIN,                          // raw pin from outside
   output logic      LEVEL                         // filtered level
);

   logic s1_reg, s2_reg, s3_reg, level_reg;
   logic level_next;

   // =========================================================
   // filter: a change counts once stages two and three agree
   always_comb begin
      level_next = level_reg;
      if (s2_reg == s3_reg) begin
         level_next = s3_reg;
      end
   end

   // stage one is read only by stage two, never by logic
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1_reg    <= INIT;
         s2_reg    <= INIT;
         s3_reg    <= INIT;
         level_reg <= INIT;
      end else begin
         s1_reg    <= PIN;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign LEVEL = level_reg;

endmodule // fbst_pin_sync

// file: rtl/fbst_tap.sv
// boundary-scan test access port of the fifo, oversampling the test clock
//
// What this block does
// - Mode select and data in are sampled on each rising test-clock edge.
// - Test outputs change only on falling test-clock edges, or at once on test reset.
// - Data in shifts into the selected instruction, id or bypass register.
// - Data out comes from the selected register, updated on falling edges.
// - Data out is high impedance except in shift-dr and shift-ir.
// - An unconnected data in reads as high.
// - An unconnected mode select reads as high.
// - Mode select steers the controller between its states.
// - Test reset low resets the controller at once, without a clock edge.
// - No self reset at power-up; test reset or five high mode samples needed.
// - Fifo data outputs stay high impedance until the controller is reset.
`timescale 1ns/1ps

module fbst_tap #(
   parameter logic [fbst_pkg::ID_W-1:0] ID_CODE = fbst_pkg::ID_DEFAULT  // arbitrary
) (
   input  wire logic CLK,                          // 40 MHz system clock
   input  wire logic RST,                          // async reset, active high
   input  wire logic TCK,                          // test clock pin
   input  wire logic TMS,                          // mode select pin
   input  wire logic TDI,                          // test data in pin
   input  wire logic TRST_N,                       // test reset pin, active low
   output logic      TDO,                          // test data out
   output logic      TDO_OE_N,                     // low while TDO is driven
   output logic      Q_OUT_EN                      // high lets fifo data outputs drive
);
   import fbst_pkg::*;

   if (ID_CODE[0] != 1'b1) begin : g_chk
      $error("ID_CODE bit 0 must be 1");
   end

   // =========================================================
   // pin synchronisers
   logic tck_q, tms_q, tdi_q, trst_n_q;

   fbst_pin_sync #(.INIT(1'b0)) u_tck (.CLK(CLK), .RST(RST), .PIN(TCK), .LEVEL(tck_q));
   // idle high stands in for the pad pull-up on an open pin
   fbst_pin_sync #(.INIT(1'b1)) u_tms (.CLK(CLK), .RST(RST), .PIN(TMS), .LEVEL(tms_q));
   fbst_pin_sync #(.INIT(1'b1)) u_tdi (.CLK(CLK), .RST(RST), .PIN(TDI), .LEVEL(tdi_q));
   fbst_pin_sync #(.INIT(1'b1)) u_trst (.CLK(CLK), .RST(RST), .PIN(TRST_N),
                                        .LEVEL(trst_n_q));

   // test clock edges found from the filtered level
   logic tck_d_reg;
   logic rise, fall;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tck_d_reg <= 1'b0;
      end else begin
         tck_d_reg <= tck_q;
      end
   end

   assign rise = tck_q & ~tck_d_reg;
   assign fall = ~tck_q & tck_d_reg;

   // raw pin as async reset: acts with no clock, so a glitch on it
   // resets the controller; the board must keep the pin clean
   logic tap_rst;
   assign tap_rst = RST | ~TRST_N;

   // =========================================================
   // controller and shift registers, advanced on rising edges
   fbst_state_t          state_reg, state_next;
   logic [IR_W-1:0]      ir_sr_reg, ir_sr_next;
   logic [IR_W-1:0]      ir_reg, ir_next;
   logic [ID_W-1:0]      dr_sr_reg, dr_sr_next;
   logic                 sel_id;

   assign sel_id = (ir_reg == OP_IDCODE);

   // next state from mode select, sixteen-state sequence
   function automatic fbst_state_t step(input fbst_state_t s, input logic m);
      case (s)
         S_TLR:    step = m ? S_TLR    : S_RTI;
         S_RTI:    step = m ? S_SEL_DR : S_RTI;
         S_SEL_DR: step = m ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: step = m ? S_EX1_DR : S_SH_DR;
         S_SH_DR:  step = m ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: step = m ? S_UPD_DR : S_PA_DR;
         S_PA_DR:  step = m ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: step = m ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: step = m ? S_SEL_DR : S_RTI;
         S_SEL_IR: step = m ? S_TLR    : S_CAP_IR;
         S_CAP_IR: step = m ? S_EX1_IR : S_SH_IR;
         S_SH_IR:  step = m ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: step = m ? S_UPD_IR : S_PA_IR;
         S_PA_IR:  step = m ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: step = m ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: step = m ? S_SEL_DR : S_RTI;
         default:  step = S_TLR;
      endcase
   endfunction

   always_comb begin
      state_next = state_reg;
      ir_sr_next = ir_sr_reg;
      ir_next    = ir_reg;
      dr_sr_next = dr_sr_reg;
      if (rise) begin
         state_next = step(state_reg, tms_q);
         case (state_reg)
            S_TLR:    ir_next = OP_IDCODE;
            S_CAP_IR: ir_sr_next = IR_CAPTURE;
            S_SH_IR:  ir_sr_next = {tdi_q, ir_sr_reg[IR_W-1:1]};
            S_UPD_IR: ir_next = ir_sr_reg;
            // bypass captures zero, id register its code
            S_CAP_DR: dr_sr_next = sel_id ? ID_CODE : '0;
            S_SH_DR: begin
               if (sel_id) begin
                  dr_sr_next = {tdi_q, dr_sr_reg[ID_W-1:1]};
               end else begin
                  dr_sr_next = {{(ID_W-1){1'b0}}, tdi_q};
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge tap_rst) begin
      if (tap_rst) begin
         state_reg <= S_TLR;
         ir_sr_reg <= IR_CAPTURE;
         ir_reg    <= OP_IDCODE;
         dr_sr_reg <= '0;
      end else begin
         state_reg <= state_next;
         ir_sr_reg <= ir_sr_next;
         ir_reg    <= ir_next;
         dr_sr_reg <= dr_sr_next;
      end
   end

   // =========================================================
   // data out, changed on falling edges only
   logic tdo_reg, tdo_next;
   logic oe_n_reg, oe_n_next;

   always_comb begin
      tdo_next  = tdo_reg;
      oe_n_next = oe_n_reg;
      if (fall) begin
         case (state_reg)
            S_SH_IR: begin
               tdo_next  = ir_sr_reg[0];
               oe_n_next = 1'b0;
            end
            S_SH_DR: begin
               tdo_next  = dr_sr_reg[0];
               oe_n_next = 1'b0;
            end
            default: oe_n_next = 1'b1;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge tap_rst) begin
      if (tap_rst) begin
         tdo_reg  <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         tdo_reg  <= tdo_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign TDO      = tdo_reg;
   assign TDO_OE_N = oe_n_reg;

   // =========================================================
   // proper-reset flag; device reset clears it, it never sets itself
   logic [2:0] ones_reg, ones_next;
   logic       ok_reg, ok_next;

   always_comb begin
      ones_next = ones_reg;
      ok_next   = ok_reg;
      if (rise) begin
         if (!tms_q) begin
            ones_next = 3'h0;
         end else if (ones_reg != ONES_MAX) begin
            ones_next = ones_reg + 3'h1;
         end
      end
      // set wins: test reset seen, or the fifth high sample
      if (!trst_n_q || (rise && tms_q && ones_reg == ONES_LAST)) begin
         ok_next = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ones_reg <= 3'h0;
         ok_reg   <= 1'b0;
      end else begin
         ones_reg <= ones_next;
         ok_reg   <= ok_next;
      end
   end

   assign Q_OUT_EN = ok_reg;

   // =========================================================
   // assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (tap_rst);

   oe_hiz_a: assert property (fall && state_reg != S_SH_DR && state_reg != S_SH_IR
      |=> TDO_OE_N) else $error("data out driven outside shift");
   tdo_fall_a: assert property (!fall |=> $stable(TDO) && $stable(TDO_OE_N))
      else $error("data out changed without falling edge");
   state_rise_a: assert property (!rise |=> $stable(state_reg))
      else $error("state moved without rising edge");
   tms_step_a: assert property (rise && state_reg == S_RTI && tms_q
      |=> state_reg == S_SEL_DR) else $error("mode select not followed");
   five_ones_a: assert property (rise && tms_q && ones_reg == ONES_LAST
      |=> state_reg == S_TLR && Q_OUT_EN) else $error("five high samples missed");
   qen_cause_a: assert property ($rose(Q_OUT_EN) |-> $past(!trst_n_q)
      || $past(ones_reg) == ONES_LAST) else $error("outputs enabled without reset");
   bypass_cap_a: assert property (rise && state_reg == S_CAP_DR && !sel_id
      |=> dr_sr_reg == '0) else $error("bypass did not capture zero");
   ir_shift_a: assert property (rise && state_reg == S_SH_IR
      |=> ir_sr_reg[IR_W-1] == $past(tdi_q)) else $error("ir shift lost data");
   tdo_src_a: assert property (fall && state_reg == S_SH_DR
      |=> TDO == $past(dr_sr_reg[0]) && !TDO_OE_N) else $error("wrong data out source");
   trst_async_a: assert property (@(posedge CLK) disable iff (RST)
      !TRST_N |-> state_reg == S_TLR && TDO_OE_N) else $error("test reset ignored");

   id_shift_c: cover property (state_reg == S_SH_DR && sel_id && fall);
   ir_update_c: cover property (rise && state_reg == S_UPD_IR);
   qen_rise_c: cover property ($rose(Q_OUT_EN));

endmodule // fbst_tap

// file: bench/fbst_test_ctrl.sv
// model of the external boundary-scan test controller
`timescale 1ns/1ps

// =========================================================
// test controller
module fbst_test_ctrl (
   input  wire logic clk,                       // system clock, paces the test clock
   output logic      tck,                       // test clock, eight system clocks a period
   output logic      tms,                       // mode select
   output logic      tdi,                       // test data in
   output logic      trst_n,                    // test reset, active low
   input  wire logic tdo,                       // test data out of the port
   input  wire logic tdo_oe_n                   // low while data out is driven
);
   logic out_bit;                               // data out seen in the last period
   logic out_off;                               // enable seen in the last period

   // parked: clock low between frames, reset released
   initial begin
      tck     = 1'b0;
      tms     = 1'b1;
      tdi     = 1'b1;
      trst_n  = 1'b1;
      out_bit = 1'b0;
      out_off = 1'b1;
   end

   // one period; data set as the clock falls, so it is stable long before the rise
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      repeat (2) @(negedge clk);
      // sampled late enough that the last falling edge has been answered
      // a released pin has no keeper: show the inverse so a stray read fails
      out_bit = tdo_oe_n ? ~tdo : tdo;
      out_off = tdo_oe_n;
      repeat (2) @(negedge clk);
      tck = 1'b0;
   endtask

   // steer the controller along a mode-select path, lsb first
   task automatic walk(input logic [7:0] path, input int n);
      for (int i = 0; i < n; i++) begin
         step(path[i], 1'b1);
      end
   endtask
endmodule // fbst_test_ctrl

// file: bench/tb_fbst_tap.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`define CHK(g, e) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end

module tb_fbst_tap;
   import fbst_pkg::*;
   logic        clk;
   logic        rst;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        trst_n;
   logic        tdo;
   logic        tdo_oe_n;
   logic        q_out_en;
   int          fails;
   int          check_count;
   logic [39:0] dout;
   logic [39:0] oen;

   fbst_tap uut (.CLK(clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
                 .TDO(tdo), .TDO_OE_N(tdo_oe_n), .Q_OUT_EN(q_out_en));
   fbst_test_ctrl ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
                       .tdo(tdo), .tdo_oe_n(tdo_oe_n));

   // =========================================================
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // =========================================================
   // shared tasks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // shift n bits, last one leaves the shift state
   task automatic scan(input logic [39:0] din, input int n);
      dout = '0;
      oen  = '0;
      for (int i = 0; i < n; i++) begin
         ctl.step(i == n - 1, din[i]);
         dout[i] = ctl.out_bit;
         oen[i]  = ctl.out_off;
      end
   endtask

   // =========================================================
   // scenarios
   task automatic t_power();
      repeat (20) @(negedge clk);
      `CHK(q_out_en, 1'b0)
      ctl.walk(8'h0f, 4);
      repeat (4) @(negedge clk);
      `CHK(q_out_en, 1'b0)
      `CHK(tdo_oe_n, 1'b1)
      ctl.step(1'b1, 1'b1);
      repeat (4) @(negedge clk);
      `CHK(q_out_en, 1'b1)
      $display("test power-up done");
   endtask

   task automatic t_idcode();
      ctl.walk(8'h02, 4);
      scan(40'hc3, 40);
      `CHK(dout, {8'hc3, ID_DEFAULT})
      `CHK(oen, 40'h0)
      ctl.walk(8'h01, 2);
      `CHK(ctl.out_off, 1'b1)
      $display("test id scan done");
   endtask

   task automatic t_bypass();
      ctl.walk(8'h03, 4);
      scan(40'hfa, 8);
      `CHK(dout[7:0], {4'ha, IR_CAPTURE})
      ctl.walk(8'h01, 2);
      ctl.walk(8'h01, 3);
      scan(40'h16, 5);
      `CHK(dout[4:0], 5'h0c)
      `CHK(oen[4:0], 5'h00)
      ctl.walk(8'h01, 2);
      $display("test bypass done");
   endtask

   task automatic t_trst();
      int n;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      `CHK(q_out_en, 1'b0)
      ctl.walk(8'h02, 4);
      ctl.step(1'b0, 1'b1);
      `CHK(ctl.out_off, 1'b0)
      // test clock parked: only the reset pin can act, pulsed as the
      // master-reset tie would pulse it
      ctl.trst_n = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(tdo_oe_n, 1'b1)
      n = 0;
      while (q_out_en !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      if (n == 10) begin
         fails++;
         wrap_up();
      end
      `CHK(q_out_en, 1'b1)
      ctl.trst_n = 1'b1;
      repeat (4) @(negedge clk);
      ctl.walk(8'h02, 4);
      scan(40'h0, 1);
      `CHK(dout[0], ID_DEFAULT[0])
      ctl.walk(8'h01, 2);
      $display("test test-reset done");
   endtask

   // =========================================================
   // main sequence
   initial begin
      rst         = 1'b1;
      fails       = 0;
      check_count = 0;
      dout        = '0;
      oen         = '0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_power();
      t_idcode();
      t_bypass();
      t_trst();
      wrap_up();
   end
endmodule // tb_fbst_tap
